/* hdl/dsau_top.sv */
`timescale 1ns/1ns
`include "dsau_consts.svh"

// Contract
// - Effective address is 16-bit byte address
// - Top bit clear: memory; set: program window
// - Window page register picks program boundary
// - Beyond implemented 8 Kbytes reads zero
// - Even byte low lane, odd high
// - Post-increment steps one byte, two word
// - Byte read selects byte onto low
// - Shared word decode, separate lane strobes
// - Odd word access traps; read still performed, write not
// - Misaligned read completes; write suppressed
// - Byte load keeps register high byte
// - Sign-extend and zero-extend operations provided
// - Lowest 2 Kbytes go to peripheral registers
// - Unassigned peripheral address reads zero
// - Independent read and write address generators
// - 2-Kbyte DMA RAM usable as RAM
// - Read, register read, write together
// - Sixteen 16-bit multipurpose working registers
// - Last working register is stack pointer
module dsau_top (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Address generator requests and register operations
    input wire dsau_pkg::dsau_rd_req_t rd_req_in,
    input wire dsau_pkg::dsau_wr_req_t wr_req_in,
    input wire dsau_pkg::dsau_reg_op_t reg_op_in,
    input wire logic [3:0] reg_sel_in,
    // Window page load
    input wire logic page_wr_in,
    input wire logic [7:0] page_data_in,
    // Read answer to the pipeline
    output logic rd_valid_out,
    output logic [15:0] rd_data_out,
    output logic rd_dma_out,
    output logic [15:0] reg_data_out,
    output logic [15:0] stack_ptr_out,
    output logic [7:0] page_out,
    // Exception logic
    output logic addr_err_out,
    // Peripheral register bus
    output logic periph_rd_out,
    output logic [15:0] periph_rd_addr_out,
    input wire logic [15:0] periph_rdata_in,
    input wire logic periph_hit_in,
    output logic periph_wr_out,
    output logic [15:0] periph_wr_addr_out,
    output logic [1:0] periph_wr_lane_out,
    output logic [15:0] periph_wr_data_out,
    // Program memory window
    output logic psv_rd_out,
    output logic [21:0] psv_word_addr_out,
    input wire logic [15:0] psv_rdata_in
);
    import dsau_pkg::*;

    // Region of a byte address
    function automatic dsau_region_t region_of(input logic [15:0] ba);
        dsau_region_t rg;
        rg = DSAU_RG_NONE;
        if (ba[`DSAU_PSV_BIT]) begin
            rg = DSAU_RG_PSV;
        end else if (ba <= `DSAU_PER_LAST) begin
            rg = DSAU_RG_PER;
        end else if (ba <= `DSAU_RAM_LAST) begin
            rg = DSAU_RG_RAM;
        end
        return rg;
    endfunction

    // Pointer step of a post-increment
    function automatic logic [15:0] step_of(input logic byte_op);
        return byte_op ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD;
    endfunction

    // Lane strobes of a write; odd word yields none
    function automatic logic [1:0] lanes_of(input logic byte_op,
                                            input logic odd);
        logic [1:0] ln;
        ln = 2'b00;
        if (byte_op) begin
            ln = odd ? 2'b10 : 2'b01;
        end else if (!odd) begin
            ln = 2'b11;
        end
        return ln;
    endfunction

    // Sixteen working registers; the last is the stack pointer
    logic [15:0] wreg_r [0:15];
    logic [7:0] page_r; // Window page

    // Read stage one: what the answer cycle needs
    logic rd_s1_r;
    dsau_region_t rd_rg_r;
    logic rd_byte_r;
    logic rd_odd_r;
    logic rd_load_r;
    logic [3:0] rd_dst_r;
    logic rd_dma_r;

    // Effective addresses from the two generators
    logic [15:0] rd_ba;
    logic [15:0] wr_ba;
    dsau_region_t rd_rg;
    dsau_region_t wr_rg;
    logic rd_mis;
    logic wr_mis;
    logic [1:0] wr_lanes;
    logic [15:0] wr_lane_data;
    logic [1:0] ram_lanes;
    logic [15:0] ram_rdata;
    logic [15:0] word_nxt;
    logic [15:0] rd_data_nxt;

    // Each generator reads its own pointer, in the same cycle
    assign rd_ba = wreg_r[rd_req_in.ptr];
    assign wr_ba = wreg_r[wr_req_in.ptr];
    assign rd_rg = region_of(rd_ba);
    assign wr_rg = region_of(wr_ba);

    // Word access at odd byte address is misaligned
    assign rd_mis = rd_req_in.valid && !rd_req_in.byte_op && rd_ba[0];
    assign wr_mis = wr_req_in.valid && !wr_req_in.byte_op && wr_ba[0];

    // Strobes are empty for a misaligned word write
    assign wr_lanes = wr_req_in.valid ?
                      lanes_of(wr_req_in.byte_op, wr_ba[0]) : 2'b00;

    // A byte value always arrives low; copy it to both lanes
    assign wr_lane_data = wr_req_in.byte_op ?
                          {wr_req_in.data[7:0], wr_req_in.data[7:0]} :
                          wr_req_in.data;

    // RAM strobes only for the implemented region
    assign ram_lanes = (wr_rg == DSAU_RG_RAM) ? wr_lanes : 2'b00;

    // Data RAM, DMA area included
    dsau_ram u_ram (
        .ref_clk_in(ref_clk_in),
        .rd_addr_in(rd_ba[`DSAU_RAM_AW:1]),
        .rd_data_out(ram_rdata),
        .wr_addr_in(wr_ba[`DSAU_RAM_AW:1]),
        .wr_lane_in(ram_lanes),
        .wr_data_in(wr_lane_data)
    );

    // Word merge of the answer cycle, from the decoded source
    always_comb begin
        case (rd_rg_r)
            DSAU_RG_RAM: begin
                word_nxt = ram_rdata;
            end
            DSAU_RG_PER: begin
                // Holes in the peripheral area read zero
                word_nxt = periph_hit_in ? periph_rdata_in : 16'h0000;
            end
            DSAU_RG_PSV: begin
                word_nxt = psv_rdata_in;
            end
            default: begin
                // Above the implemented memory
                word_nxt = 16'h0000;
            end
        endcase
    end

    // Byte read picks its lane and places it low
    always_comb begin
        if (rd_byte_r) begin
            rd_data_nxt = {8'h00, rd_odd_r ? word_nxt[15:8] :
                                             word_nxt[7:0]};
        end else begin
            rd_data_nxt = word_nxt;
        end
    end

    // Read stage one capture
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_s1_r <= 1'b0;
            rd_rg_r <= DSAU_RG_NONE;
            rd_byte_r <= 1'b0;
            rd_odd_r <= 1'b0;
            rd_load_r <= 1'b0;
            rd_dst_r <= 4'h0;
            rd_dma_r <= 1'b0;
        end else begin
            rd_s1_r <= rd_req_in.valid;
            rd_rg_r <= rd_rg;
            rd_byte_r <= rd_req_in.byte_op;
            rd_odd_r <= rd_ba[0];
            rd_load_r <= rd_req_in.valid && rd_req_in.load;
            rd_dst_r <= rd_req_in.dst;
            // DMA RAM is ordinary RAM to the core; only flagged
            rd_dma_r <= (rd_rg == DSAU_RG_RAM) &&
                        (rd_ba >= `DSAU_DMA_FIRST);
        end
    end

    // Read answer; a misaligned read still completes as aligned
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 16'h0000;
            rd_dma_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_s1_r;
            rd_data_out <= rd_data_nxt;
            rd_dma_out <= rd_s1_r && rd_dma_r;
        end
    end

    // Error pulse one cycle after the offending request
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_err_out <= 1'b0;
        end else begin
            addr_err_out <= rd_mis || wr_mis;
        end
    end

    // Peripheral read address and strobe
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            periph_rd_out <= 1'b0;
            periph_rd_addr_out <= 16'h0000;
        end else begin
            periph_rd_out <= rd_req_in.valid && (rd_rg == DSAU_RG_PER);
            periph_rd_addr_out <= {rd_ba[15:1], 1'b0};
        end
    end

    // Peripheral write; a misaligned word write carries no strobe
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            periph_wr_out <= 1'b0;
            periph_wr_addr_out <= 16'h0000;
            periph_wr_lane_out <= 2'b00;
            periph_wr_data_out <= 16'h0000;
        end else begin
            periph_wr_out <= (wr_rg == DSAU_RG_PER) &&
                             (wr_lanes != 2'b00);
            periph_wr_addr_out <= {wr_ba[15:1], 1'b0};
            periph_wr_lane_out <= (wr_rg == DSAU_RG_PER) ?
                                  wr_lanes : 2'b00;
            periph_wr_data_out <= wr_lane_data;
        end
    end

    // Window access; the window is read-only from data space
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            psv_rd_out <= 1'b0;
            psv_word_addr_out <= 22'h000000;
        end else begin
            psv_rd_out <= rd_req_in.valid && (rd_rg == DSAU_RG_PSV);
            psv_word_addr_out <= {page_r, rd_ba[14:1]};
        end
    end

    // Window page register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            page_r <= `DSAU_PAGE_RST;
        end else if (page_wr_in) begin
            page_r <= page_data_in;
        end
    end

    // Working registers; later writes in the block take priority:
    // read-data load, then direct operation, then pointer steps
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 16; i++) begin
                wreg_r[i] <= `DSAU_WREG_RST;
            end
            wreg_r[`DSAU_SP_IDX] <= `DSAU_SP_RST;
        end else begin
            // Loads from a completed read
            if (rd_load_r) begin
                if (rd_byte_r) begin
                    wreg_r[rd_dst_r][7:0] <= rd_data_nxt[7:0];
                end else begin
                    wreg_r[rd_dst_r] <= rd_data_nxt;
                end
            end
            // Direct operations from the pipeline
            if (reg_op_in.valid) begin
                case (reg_op_in.op)
                    DSAU_OP_LOADW: begin
                        wreg_r[reg_op_in.dst] <= reg_op_in.data;
                    end
                    DSAU_OP_LOADB: begin
                        wreg_r[reg_op_in.dst][7:0] <=
                            reg_op_in.data[7:0];
                    end
                    DSAU_OP_SEXT: begin
                        wreg_r[reg_op_in.dst] <=
                            {{8{reg_op_in.data[7]}},
                             reg_op_in.data[7:0]};
                    end
                    DSAU_OP_ZEXT: begin
                        wreg_r[reg_op_in.dst][15:8] <= 8'h00;
                    end
                    default: begin
                        // No operation
                    end
                endcase
            end
            // Pointer steps of both generators
            if (rd_req_in.valid && rd_req_in.post_inc) begin
                wreg_r[rd_req_in.ptr] <=
                    rd_ba + step_of(rd_req_in.byte_op);
            end
            if (wr_req_in.valid && wr_req_in.post_inc) begin
                wreg_r[wr_req_in.ptr] <=
                    wr_ba + step_of(wr_req_in.byte_op);
            end
        end
    end

    // Register read port, stack pointer and page views
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_data_out <= `DSAU_WREG_RST;
            stack_ptr_out <= `DSAU_SP_RST;
            page_out <= `DSAU_PAGE_RST;
        end else begin
            reg_data_out <= wreg_r[reg_sel_in];
            stack_ptr_out <= wreg_r[`DSAU_SP_IDX];
            page_out <= page_r;
        end
    end
endmodule

/* hdl/dsau_consts.svh */
`ifndef DSAU_CONSTS_SVH
`define DSAU_CONSTS_SVH

// Region bounds inside the lower half of data space
`define DSAU_PER_LAST 16'h07ff
`define DSAU_RAM_LAST 16'h1fff
`define DSAU_DMA_FIRST 16'h1800
// Top address bit selects the program-space window
`define DSAU_PSV_BIT 15
// Word index width of the implemented 8 Kbyte array
`define DSAU_RAM_AW 12
// Post-increment steps for byte and word operations
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
// Index of the working register used as stack pointer
`define DSAU_SP_IDX 4'hf
// Reset values
`define DSAU_WREG_RST 16'h0000
`define DSAU_SP_RST 16'h0800
`define DSAU_PAGE_RST 8'h00

`endif

/* hdl/dsau_pkg.sv */
package dsau_pkg;

    // Decoded target of one effective address
    typedef enum logic [1:0] {
        DSAU_RG_PER  = 2'b00,
        DSAU_RG_RAM  = 2'b01,
        DSAU_RG_NONE = 2'b10,
        DSAU_RG_PSV  = 2'b11
    } dsau_region_t;

    // Direct working register operations
    typedef enum logic [2:0] {
        DSAU_OP_NONE  = 3'b000,
        DSAU_OP_LOADW = 3'b001,
        DSAU_OP_LOADB = 3'b010,
        DSAU_OP_SEXT  = 3'b011,
        DSAU_OP_ZEXT  = 3'b100
    } dsau_regop_t;

    // Read request from the read address generator
    typedef struct packed {
        logic       valid;
        logic       byte_op;
        logic [3:0] ptr;
        logic       post_inc;
        logic       load;
        logic [3:0] dst;
    } dsau_rd_req_t;

    // Write request from the write address generator
    typedef struct packed {
        logic        valid;
        logic        byte_op;
        logic [3:0]  ptr;
        logic        post_inc;
        logic [15:0] data;
    } dsau_wr_req_t;

    // Direct register operation from the pipeline
    typedef struct packed {
        logic        valid;
        dsau_regop_t op;
        logic [3:0]  dst;
        logic [15:0] data;
    } dsau_reg_op_t;

endpackage

/* hdl/dsau_ram.sv */
`timescale 1ns/1ns
`include "dsau_consts.svh"

// Two byte lanes, one shared word decode, one strobe per lane
module dsau_ram (
    // Clock
    input wire logic ref_clk_in,
    // Read port
    input wire logic [`DSAU_RAM_AW-1:0] rd_addr_in,
    output logic [15:0] rd_data_out,
    // Write port
    input wire logic [`DSAU_RAM_AW-1:0] wr_addr_in,
    input wire logic [1:0] wr_lane_in,
    input wire logic [15:0] wr_data_in
);
    // Storage has no reset, as real RAM powers up unknown
    logic [7:0] lo_mem [0:(1<<`DSAU_RAM_AW)-1];
    logic [7:0] hi_mem [0:(1<<`DSAU_RAM_AW)-1];

    // Low lane holds even bytes
    always_ff @(posedge ref_clk_in) begin
        if (wr_lane_in[0]) begin
            lo_mem[wr_addr_in] <= wr_data_in[7:0];
        end
    end

    // High lane holds odd bytes
    always_ff @(posedge ref_clk_in) begin
        if (wr_lane_in[1]) begin
            hi_mem[wr_addr_in] <= wr_data_in[15:8];
        end
    end

    // Registered read; a same-cycle write to the word reads old data
    always_ff @(posedge ref_clk_in) begin
        rd_data_out <= {hi_mem[rd_addr_in], lo_mem[rd_addr_in]};
    end
endmodule

/* test/dsau_top_asserts.sv */
`timescale 1ns/1ns

// Port-level timing checks for the data space access unit
module dsau_top_asserts (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Requests from the address generators
    input wire dsau_pkg::dsau_rd_req_t rd_req_in,
    input wire dsau_pkg::dsau_wr_req_t wr_req_in,
    // Read answer and exception
    input wire logic rd_valid_out,
    input wire logic [15:0] rd_data_out,
    input wire logic rd_dma_out,
    input wire logic addr_err_out,
    // Peripheral and program window buses
    input wire logic periph_rd_out,
    input wire logic [15:0] periph_rd_addr_out,
    input wire logic periph_wr_out,
    input wire logic [15:0] periph_wr_addr_out,
    input wire logic [1:0] periph_wr_lane_out,
    input wire logic [15:0] periph_wr_data_out,
    input wire logic psv_rd_out
);
    import dsau_pkg::*;
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // Every read is answered exactly two cycles after it is taken
    property p_rd_lat;
        rd_req_in.valid |-> ##2 rd_valid_out;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");
    // No answer without a request two cycles earlier
    property p_rd_cause;
        rd_valid_out |-> $past(rd_req_in.valid, 2);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("spurious read answer");
    // Error pulse only after a word request
    property p_err_cause;
        addr_err_out |-> $past(rd_req_in.valid && !rd_req_in.byte_op ||
            wr_req_in.valid && !wr_req_in.byte_op);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("address error without word access");
    // A faulting write must not reach the peripheral strobe
    property p_err_gate;
        addr_err_out && $past(wr_req_in.valid && !rd_req_in.valid)
            |-> !periph_wr_out;
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("misaligned write not suppressed");
    // Word writes strobe both lanes
    property p_lane_word;
        periph_wr_out && !$past(wr_req_in.byte_op) |->
            periph_wr_lane_out == 2'b11;
    endproperty
    a_lane_word: assert property (p_lane_word)
        else $error("word write lanes wrong");
    // Byte writes strobe one lane, data copied on both
    property p_lane_byte;
        periph_wr_out && $past(wr_req_in.byte_op) |->
            $onehot(periph_wr_lane_out) &&
            periph_wr_data_out[15:8] == periph_wr_data_out[7:0];
    endproperty
    a_lane_byte: assert property (p_lane_byte)
        else $error("byte write lanes wrong");
    // Peripheral reads stay word aligned inside the lowest 2 Kbytes
    property p_periph_rd;
        periph_rd_out |-> !periph_rd_addr_out[0] &&
            periph_rd_addr_out <= 16'h07ff && $past(rd_req_in.valid);
    endproperty
    a_periph_rd: assert property (p_periph_rd)
        else $error("peripheral read out of region");
    // Peripheral writes likewise
    property p_periph_wr;
        periph_wr_out |-> !periph_wr_addr_out[0] &&
            periph_wr_addr_out <= 16'h07ff && $past(wr_req_in.valid);
    endproperty
    a_periph_wr: assert property (p_periph_wr)
        else $error("peripheral write out of region");
    // Window reads follow a read and never overlap peripheral reads
    property p_psv;
        psv_rd_out |-> $past(rd_req_in.valid) && !periph_rd_out;
    endproperty
    a_psv: assert property (p_psv)
        else $error("window read without cause");
    // Byte answers carry zero in the high byte
    property p_byte_hi;
        rd_valid_out && $past(rd_req_in.byte_op, 2) |->
            rd_data_out[15:8] == 8'h00;
    endproperty
    a_byte_hi: assert property (p_byte_hi)
        else $error("byte read high byte not zero");
    // DMA flag only rides on an answer
    property p_dma;
        rd_dma_out |-> rd_valid_out;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma flag without answer");
endmodule

bind dsau_top dsau_top_asserts i_dsau_top_asserts (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rd_req_in(rd_req_in),
    .wr_req_in(wr_req_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .rd_dma_out(rd_dma_out),
    .addr_err_out(addr_err_out), .periph_rd_out(periph_rd_out),
    .periph_rd_addr_out(periph_rd_addr_out), .periph_wr_out(periph_wr_out),
    .periph_wr_addr_out(periph_wr_addr_out),
    .periph_wr_lane_out(periph_wr_lane_out),
    .periph_wr_data_out(periph_wr_data_out), .psv_rd_out(psv_rd_out));

/* test/dsau_periph_model.sv */
`timescale 1ns/1ns

// One peripheral register plus a program memory responder
module dsau_periph_model #(
    parameter logic [15:0] REG_ADDR = 16'h0400,
    parameter logic [15:0] REG_RST = 16'h0000
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Peripheral bus
    input wire logic rd_in,
    input wire logic [15:0] rd_addr_in,
    output logic [15:0] rdata_out,
    output logic hit_out,
    input wire logic wr_in,
    input wire logic [15:0] wr_addr_in,
    input wire logic [1:0] wr_lane_in,
    input wire logic [15:0] wr_data_in,
    // Program memory window
    input wire logic psv_rd_in,
    input wire logic [21:0] psv_addr_in,
    output logic [15:0] psv_rdata_out
);
    logic [15:0] reg_r; // The only assigned register
    logic [15:0] noise_r; // Changes every cycle so stale data never matches

    // Noise pattern for idle or unassigned replies
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            noise_r <= 16'ha5a5;
        end else begin
            noise_r <= ~noise_r;
        end
    end

    // Lane-wise register update
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_r <= REG_RST;
        end else if (wr_in && wr_addr_in == REG_ADDR) begin
            if (wr_lane_in[0]) reg_r[7:0] <= wr_data_in[7:0];
            if (wr_lane_in[1]) reg_r[15:8] <= wr_data_in[15:8];
        end
    end

    // Unassigned addresses miss but still drive noise on the data
    assign hit_out = rd_in && rd_addr_in == REG_ADDR;
    assign rdata_out = hit_out ? reg_r : noise_r;
    // Program words are a fixed function of their word address
    assign psv_rdata_out = psv_rd_in ? psv_addr_in[15:0] ^ 16'h0f0f : noise_r;
endmodule

/* test/dsau_top_tb.sv */
`timescale 1ns/1ns
`include "dsau_consts.svh"

module dsau_top_tb;
    import dsau_pkg::*;
    // Table row: write flag, byte flag, address, data or expected
    typedef struct packed {
        logic wr; logic b; logic [15:0] a; logic [15:0] d;
    } dsau_row_t;
    logic ref_clk_in, rst_in, page_wr_in;
    dsau_rd_req_t rd_req_in;
    dsau_wr_req_t wr_req_in;
    dsau_reg_op_t reg_op_in;
    logic [3:0] reg_sel_in;
    logic [7:0] page_data_in, page_out;
    logic rd_valid_out, rd_dma_out, addr_err_out, periph_hit_in;
    logic [15:0] rd_data_out, reg_data_out, stack_ptr_out, periph_rdata_in;
    logic periph_rd_out, periph_wr_out, psv_rd_out;
    logic [15:0] periph_rd_addr_out, periph_wr_addr_out, periph_wr_data_out;
    logic [15:0] psv_rdata_in;
    logic [1:0] periph_wr_lane_out;
    logic [21:0] psv_word_addr_out;
    int error_cnt, n_checks, n;
    dsau_row_t rows [0:19] = '{
        '{1,0,16'h0800,16'h1234}, '{0,0,16'h0800,16'h1234},
        '{0,1,16'h0800,16'h0034}, '{0,1,16'h0801,16'h0012},
        '{1,1,16'h0801,16'h00ab}, '{0,0,16'h0800,16'hab34},
        '{1,0,16'h0802,16'h4444}, '{1,0,16'h1ffe,16'hbeef},
        '{0,0,16'h1ffe,16'hbeef}, '{0,1,16'h1fff,16'h00be},
        '{1,0,16'h2000,16'h5555}, '{0,0,16'h2000,16'h0000},
        '{0,1,16'h7fff,16'h0000}, '{1,0,16'h0400,16'h1357},
        '{1,1,16'h0401,16'h009a}, '{0,0,16'h0400,16'h9a57},
        '{0,1,16'h0401,16'h009a}, '{0,0,16'h0402,16'h0000},
        '{0,0,16'h8010,16'h8f07}, '{0,1,16'h8011,16'h008f}};

    dsau_top i_dsau_top (.*);
    dsau_periph_model i_dsau_periph_model (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .rd_in(periph_rd_out), .rd_addr_in(periph_rd_addr_out),
        .rdata_out(periph_rdata_in), .hit_out(periph_hit_in),
        .wr_in(periph_wr_out), .wr_addr_in(periph_wr_addr_out),
        .wr_lane_in(periph_wr_lane_out), .wr_data_in(periph_wr_data_out),
        .psv_rd_in(psv_rd_out), .psv_addr_in(psv_word_addr_out),
        .psv_rdata_out(psv_rdata_in));

    // 100 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Inputs always move 1 ns after the rising edge
    task tick;
        @(posedge ref_clk_in);
        #1;
    endtask
    // Launch what is set up, then drop every request
    task step;
        tick;
        rd_req_in = '0;
        wr_req_in = '0;
        reg_op_in = '0;
        page_wr_in = 1'b0;
    endtask
    task reg_op(input dsau_regop_t op, input logic [3:0] d, input logic [15:0] v);
        reg_op_in = '{valid: 1'b1, op: op, dst: d, data: v};
        step;
    endtask
    task rd_set(input logic [3:0] p, input logic b, i, l, input logic [3:0] d);
        rd_req_in = '{valid: 1'b1, byte_op: b, ptr: p, post_inc: i,
            load: l, dst: d};
    endtask
    task wr_set(input logic [3:0] p, input logic b, i, input logic [15:0] v);
        wr_req_in = '{valid: 1'b1, byte_op: b, ptr: p, post_inc: i, data: v};
    endtask
    // Bounded wait for the answer, called one cycle after the request
    task rd_get(input logic [15:0] exp);
        n = 0;
        do begin
            tick;
            n++;
        end while (rd_valid_out !== 1'b1 && n < 4);
        if (n == 4) begin
            error_cnt++;
            end_of_test;
        end else begin
            chk(16'(n), 16'h0001);
            chk(rd_data_out, exp);
        end
    endtask
    task rd(input logic [15:0] a, input logic b, input logic [15:0] exp);
        reg_op(DSAU_OP_LOADW, 4'h1, a);
        rd_set(4'h1, b, 1'b0, 1'b0, 4'h0);
        step;
        rd_get(exp);
    endtask
    // Show a working register one cycle later
    task see(input logic [3:0] r, input logic [15:0] exp);
        reg_sel_in = r;
        tick;
        chk(reg_data_out, exp);
    endtask

    initial begin
        rst_in = 1'b1;
        {rd_req_in, wr_req_in, reg_op_in, reg_sel_in} = '0;
        {page_wr_in, page_data_in} = '0;
        repeat (4) tick;
        rst_in = 1'b0;
        tick;
        chk(stack_ptr_out, `DSAU_SP_RST);
        chk(page_out, 16'h0000);
        page_wr_in = 1'b1;
        page_data_in = 8'h5a;
        step;
        tick;
        chk(page_out, 16'h005a);
        $display("reset done");
        for (int k = 0; k < 20; k++) begin
            reg_op(DSAU_OP_LOADW, 4'h1, rows[k].a);
            if (rows[k].wr) begin
                wr_set(4'h1, rows[k].b, 1'b0, rows[k].d);
                step;
            end else begin
                rd_set(4'h1, rows[k].b, 1'b0, 1'b0, 4'h0);
                step;
                rd_get(rows[k].d);
                chk(rd_dma_out, rows[k].a inside {[16'h1800:16'h1fff]});
            end
        end
        $display("table done");
        reg_op(DSAU_OP_LOADW, 4'h1, 16'h0801);
        rd_set(4'h1, 1'b0, 1'b0, 1'b0, 4'h0);
        step;
        chk(addr_err_out, 16'h0001);
        rd_get(16'hab34);
        chk(addr_err_out, 16'h0000);
        foreach (rows[k]) if (k < 2) begin
            reg_op(DSAU_OP_LOADW, 4'h1, k ? 16'h0401 : 16'h0803);
            wr_set(4'h1, 1'b0, 1'b0, 16'hffff);
            step;
            chk(addr_err_out, 16'h0001);
            chk(periph_wr_out, 16'h0000);
        end
        rd(16'h0802, 1'b0, 16'h4444);
        rd(16'h0400, 1'b0, 16'h9a57);
        $display("misaligned done");
        reg_op(DSAU_OP_LOADW, 4'h3, 16'h0800);
        rd_set(4'h3, 1'b1, 1'b1, 1'b0, 4'h0);
        step;
        rd_get(16'h0034);
        see(4'h3, 16'h0801);
        wr_set(4'h3, 1'b1, 1'b1, 16'h0055);
        step;
        see(4'h3, 16'h0802);
        rd_set(4'h3, 1'b0, 1'b1, 1'b0, 4'h0);
        step;
        rd_get(16'h4444);
        see(4'h3, 16'h0804);
        rd(16'h0800, 1'b0, 16'h5534);
        $display("postinc done");
        reg_op(DSAU_OP_LOADW, 4'h4, 16'hffff);
        rd_set(4'h1, 1'b1, 1'b0, 1'b1, 4'h4);
        step;
        rd_get(16'h0034);
        see(4'h4, 16'hff34);
        reg_op(DSAU_OP_ZEXT, 4'h4, 16'h0000);
        see(4'h4, 16'h0034);
        reg_op(DSAU_OP_SEXT, 4'h5, 16'h0080);
        see(4'h5, 16'hff80);
        reg_op(DSAU_OP_SEXT, 4'h5, 16'h007f);
        see(4'h5, 16'h007f);
        reg_op(DSAU_OP_LOADB, 4'h3, 16'hff99);
        see(4'h3, 16'h0899);
        $display("regop done");
        reg_op(DSAU_OP_LOADW, 4'h2, 16'h0802);
        rd_set(4'h2, 1'b0, 1'b0, 1'b0, 4'h0);
        wr_set(4'h2, 1'b0, 1'b0, 16'h6789);
        step;
        rd_get(16'h4444);
        rd(16'h0802, 1'b0, 16'h6789);
        reg_op(DSAU_OP_LOADW, 4'hf, 16'h0ffe);
        tick;
        chk(stack_ptr_out, 16'h0ffe);
        $display("stack done");
        rst_in = 1'b1;
        tick;
        chk(stack_ptr_out, `DSAU_SP_RST);
        chk(page_out, 16'h0000);
        rst_in = 1'b0;
        tick;
        rd(16'h0800, 1'b0, 16'h5534);
        $display("reset2 done");
        end_of_test;
    end
endmodule
